// *** design/sfrx_top.sv ***
// Purpose: register area select, per-module page registers with save/restore, write guard
// Assumes: cpu core register port on clk_sys, single cycle write and read strobes
// Notes: read data is registered and valid one cycle after the read strobe
`timescale 1ns/1ps
`default_nettype none
module sfrx_top
  import sfrx_pkg::*;
(
  input wire logic clk_sys, // system clock
  input wire logic rstn, // async reset, active low
  input wire logic cpu_wr, // register write strobe
  input wire logic cpu_rd, // register read strobe
  input wire logic [7:0] cpu_addr, // register address 80..ff
  input wire logic [7:0] cpu_wdata, // write data
  output logic [7:0] cpu_rdata, // read data, registered
  output logic cpu_rvalid, // read data valid pulse
  output logic cpu_rhit, // read hit one of our registers
  output logic map_select_bit, // current area, 1 = mapped
  output logic [SFRX_NMOD-1:0][2:0] page_active, // active page per module
  output logic [3:0] clock_divider_setting, // guarded
  output logic watchdog_enable_bit, // guarded
  output logic power_down_request, // guarded
  output logic slow_down_request, // guarded
  output logic guard_blocked // 1 while protected writes are blocked
);

  function automatic sfrx_page_s page_next(sfrx_page_s cur, logic [7:0] w);
    sfrx_page_s nx;
    logic [1:0] sn;
    nx = cur;
    sn = w[SFRX_SLOT_LSB +: 2];
    case (sfrx_act_e'(w[SFRX_ACT_LSB +: 2]))
      SFRX_ACT_SAVE: begin
        nx.slot[sn] = cur.page;
        nx.page = w[SFRX_PAGE_LSB +: 3];
      end
      SFRX_ACT_REST: begin
        nx.page = cur.slot[sn];
      end
      default: begin
        nx.page = w[SFRX_PAGE_LSB +: 3];
      end
    endcase
    return nx;
  endfunction

  function automatic logic [7:0] page_addr(int i);
    logic [7:0] a;
    a = SFRX_PG_SCU_ADDR;
    if (i == 0) begin
      a = SFRX_PG_PORT_ADDR;
    end else if (i == 1) begin
      a = SFRX_PG_ADC_ADDR;
    end else if (i == 2) begin
      a = SFRX_PG_CC_ADDR;
    end
    return a;
  endfunction

  sfrx_req_s req;
  logic [7:0] area_q, area_d;
  sfrx_page_s [SFRX_NMOD-1:0] pg_q, pg_d;
  logic [1:0] mode_q, mode_d;
  logic open_q, open_d;
  logic [4:0] cnt_q, cnt_d;
  logic [7:0] prot_q, prot_d;
  logic [7:0] rdata_q, rdata_d;
  logic rvalid_q, rvalid_d;
  logic rhit_q, rhit_d;
  logic [4:0] pass;
  logic guard_wr, writable;

  assign req = '{sel: cpu_wr | cpu_rd, wr: cpu_wr, rd: cpu_rd, addr: cpu_addr,
                 wdata: cpu_wdata};
  assign pass = req.wdata[SFRX_PASS_LSB +: 5];
  assign guard_wr = req.wr && (req.addr == SFRX_GUARD_ADDR);
  // scheme disabled counts as permanently open
  assign writable = open_q || (mode_q == SFRX_MODE_OFF);

  // area register
  always_comb begin
    area_d = area_q;
    if (req.wr && req.addr == SFRX_AREA_ADDR) begin
      area_d = 8'h00;
      area_d[SFRX_MAP_BIT] = req.wdata[SFRX_MAP_BIT];
      area_d[SFRX_KEEP_BIT] = req.wdata[SFRX_KEEP_BIT];
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      area_q <= SFRX_AREA_RST;
    end else begin
      area_q <= area_d;
    end
  end

  // page registers, one per paged module, all in the standard area
  always_comb begin
    pg_d = pg_q;
    for (int i = 0; i < SFRX_NMOD; i++) begin
      if (req.wr && !area_q[SFRX_MAP_BIT] && req.addr == page_addr(i)) begin
        pg_d[i] = page_next(pg_q[i], req.wdata);
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pg_q <= '0;
    end else begin
      pg_q <= pg_d;
    end
  end

  // write guard
  always_comb begin
    mode_d = mode_q;
    open_d = open_q;
    cnt_d = cnt_q;
    if (open_q) begin
      if (cnt_q == SFRX_WIN_LAST) begin
        open_d = 1'b0;
        cnt_d = 5'h00;
      end else begin
        cnt_d = cnt_q + 5'h01;
      end
    end
    if (guard_wr) begin
      if (pass == SFRX_PASS_MODE) begin
        mode_d = req.wdata[1:0];
      end else if (pass == SFRX_PASS_OPEN && mode_q == SFRX_MODE_ON) begin
        open_d = 1'b1;
        cnt_d = 5'h00;
      end else if (pass == SFRX_PASS_CLOSE) begin
        open_d = 1'b0;
        cnt_d = 5'h00;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      mode_q <= SFRX_MODE_RST;
      open_q <= 1'b0;
      cnt_q <= 5'h00;
    end else begin
      mode_q <= mode_d;
      open_q <= open_d;
      cnt_q <= cnt_d;
    end
  end

  // protected control bits
  always_comb begin
    prot_d = prot_q;
    if (req.wr && req.addr == SFRX_PROT_ADDR && writable) begin
      prot_d = {1'b0, req.wdata[6:0]};
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      prot_q <= SFRX_PROT_RST;
    end else begin
      prot_q <= prot_d;
    end
  end

  // read path
  always_comb begin
    rdata_d = 8'h00;
    rhit_d = 1'b0;
    rvalid_d = req.rd;
    if (req.rd) begin
      if (req.addr == SFRX_AREA_ADDR) begin
        rdata_d = area_q;
        rhit_d = 1'b1;
      end else if (req.addr == SFRX_GUARD_ADDR) begin
        rdata_d = {5'h00, !writable, mode_q};
        rhit_d = 1'b1;
      end else if (req.addr == SFRX_PROT_ADDR) begin
        rdata_d = prot_q;
        rhit_d = 1'b1;
      end else if (!area_q[SFRX_MAP_BIT]) begin
        for (int i = 0; i < SFRX_NMOD; i++) begin
          if (req.addr == page_addr(i)) begin
            rdata_d = {5'h00, pg_q[i].page};
            rhit_d = 1'b1;
          end
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
      rhit_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
      rhit_q <= rhit_d;
    end
  end

  assign cpu_rdata = rdata_q;
  assign cpu_rvalid = rvalid_q;
  assign cpu_rhit = rhit_q;
  assign map_select_bit = area_q[SFRX_MAP_BIT];
  assign clock_divider_setting = prot_q[3:0];
  assign watchdog_enable_bit = prot_q[4];
  assign power_down_request = prot_q[5];
  assign slow_down_request = prot_q[6];
  assign guard_blocked = !writable;

  always_comb begin
    for (int i = 0; i < SFRX_NMOD; i++) begin
      page_active[i] = pg_q[i].page;
    end
  end

  // checks
  // age counts cycles since the last accepted opening password, apart from the guard's
  // own counter; it stops one past the window so a late close is still caught
  logic [5:0] open_run_q, open_run_d;
  logic [5:0] open_age_q, open_age_d;
  logic open_key;
  assign open_key = guard_wr && pass == SFRX_PASS_OPEN && mode_q == SFRX_MODE_ON;

  always_comb begin
    open_run_d = 6'h00;
    if (open_d && !(guard_wr && pass == SFRX_PASS_OPEN)) begin
      open_run_d = open_run_q + 6'h01;
    end
    open_age_d = open_age_q;
    if (open_key) begin
      open_age_d = 6'h01;
    end else if (guard_wr && pass == SFRX_PASS_CLOSE) begin
      open_age_d = 6'h00;
    end else if (open_age_q != 6'h00 && open_age_q != 6'(SFRX_WINDOW_CPU_CLOCK + 1)) begin
      open_age_d = open_age_q + 6'h01;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      open_run_q <= 6'h00;
      open_age_q <= 6'h00;
    end else begin
      open_run_q <= open_run_d;
      open_age_q <= open_age_d;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  AST_MAP_FOLLOWS_WRITE: assert property (
    req.wr && req.addr == SFRX_AREA_ADDR |=> map_select_bit == $past(req.wdata[0]))
    else $error("map bit does not follow write");
  AST_MAP_HOLDS: assert property (
    !(req.wr && req.addr == SFRX_AREA_ADDR) |=> $stable(map_select_bit))
    else $error("map bit changed without write");
  AST_AREA_RESERVED: assert property (
    cpu_rvalid && cpu_rhit && $past(req.addr) == SFRX_AREA_ADDR |-> cpu_rdata[7:3] == 5'h00
    && !cpu_rdata[1]) else $error("reserved area bits not zero");
  AST_SAVE_SLOT: assert property (
    req.wr && !map_select_bit && req.addr == SFRX_PG_PORT_ADDR && req.wdata[7:6] == 2'b10
    |=> pg_q[0].slot[$past(req.wdata[5:4])] == $past(pg_q[0].page)
    && page_active[0] == $past(req.wdata[2:0])) else $error("save action wrong");
  AST_RESTORE_SLOT: assert property (
    req.wr && !map_select_bit && req.addr == SFRX_PG_ADC_ADDR && req.wdata[7:6] == 2'b11
    |=> page_active[1] == $past(pg_q[1].slot[req.wdata[5:4]])) else $error("restore wrong");
  AST_OPEN: assert property (
    guard_wr && pass == SFRX_PASS_OPEN && mode_q == SFRX_MODE_ON |=> !guard_blocked)
    else $error("open password failed");
  AST_WINDOW_OPEN: assert property (
    open_age_q != 6'h00 && open_age_q <= 6'(SFRX_WINDOW_CPU_CLOCK) |-> open_q)
    else $error("window closed before 32 cycles");
  AST_CLOSE: assert property (
    guard_wr && pass == SFRX_PASS_CLOSE && mode_q == SFRX_MODE_ON |=> guard_blocked)
    else $error("close password failed");
  AST_WINDOW_MAX: assert property (
    open_run_q <= 6'(SFRX_WINDOW_CPU_CLOCK)) else $error("window longer than 32 cycles");
  AST_WINDOW_END: assert property (
    open_age_q == 6'(SFRX_WINDOW_CPU_CLOCK + 1) |-> !open_q)
    else $error("window did not close");
  AST_GUARD_BLOCKS: assert property (
    guard_blocked && req.wr && req.addr == SFRX_PROT_ADDR |=> $stable(prot_q))
    else $error("protected bits written while closed");
  AST_MODE_KEY: assert property (
    !(guard_wr && pass == SFRX_PASS_MODE) |=> $stable(mode_q))
    else $error("mode changed without key");

  COV_SAVE: cover property (req.wr && req.wdata[7:6] == 2'b10 && req.addr == SFRX_PG_CC_ADDR);
  COV_TIMEOUT: cover property ($fell(open_q) && !$past(guard_wr));
  COV_REOPEN: cover property (open_q && guard_wr && pass == SFRX_PASS_OPEN);
  COV_MAPPED: cover property (map_select_bit && cpu_rvalid && cpu_rhit);
endmodule
`default_nettype wire

// *** design/sfrx_pkg.sv ***
// Purpose: constants and types for the register area select, page and write guard block
// Assumes: 8-bit register port from the cpu core, one clock
// Notes: page register and guard addresses are fixed here
package sfrx_pkg;
  localparam logic [7:0] SFRX_AREA_ADDR = 8'h8f;
  localparam logic [7:0] SFRX_PG_PORT_ADDR = 8'hb2;
  localparam logic [7:0] SFRX_PG_ADC_ADDR = 8'hd1;
  localparam logic [7:0] SFRX_PG_CC_ADDR = 8'ha3;
  localparam logic [7:0] SFRX_PG_SCU_ADDR = 8'hbf;
  localparam logic [7:0] SFRX_GUARD_ADDR = 8'hbb;
  localparam logic [7:0] SFRX_PROT_ADDR = 8'hb7;
  localparam logic [7:0] SFRX_AREA_RST = 8'h04;
  localparam logic [7:0] SFRX_PROT_RST = 8'h00;
  localparam logic [1:0] SFRX_MODE_RST = 2'h3;
  localparam logic [1:0] SFRX_MODE_ON = 2'h3;
  localparam logic [1:0] SFRX_MODE_OFF = 2'h0;
  localparam int SFRX_MAP_BIT = 0;
  localparam int SFRX_KEEP_BIT = 2;
  localparam int SFRX_PAGE_LSB = 0;
  localparam int SFRX_SLOT_LSB = 4;
  localparam int SFRX_ACT_LSB = 6;
  localparam int SFRX_PASS_LSB = 3;
  localparam int SFRX_PSTAT_BIT = 2;
  localparam logic [4:0] SFRX_PASS_MODE = 5'h18;
  localparam logic [4:0] SFRX_PASS_OPEN = 5'h13;
  localparam logic [4:0] SFRX_PASS_CLOSE = 5'h15;
  localparam int SFRX_WINDOW_CPU_CLOCK = 32;
  localparam logic [4:0] SFRX_WIN_LAST = 5'(SFRX_WINDOW_CPU_CLOCK - 1);
  localparam int SFRX_NMOD = 4;

  typedef enum logic [1:0] {
    SFRX_ACT_MAN0 = 2'b00,
    SFRX_ACT_MAN1 = 2'b01,
    SFRX_ACT_SAVE = 2'b10,
    SFRX_ACT_REST = 2'b11
  } sfrx_act_e;

  typedef struct packed {
    logic [3:0][2:0] slot;
    logic [2:0] page;
  } sfrx_page_s;

  typedef struct packed {
    logic sel;
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfrx_req_s;
endpackage

// *** sim/sfrx_cpu_model.sv ***
// Purpose: cpu core side of the register port, issues reads and writes
// Assumes: block samples strobes on rising clk_sys, read data one cycle later
// Notes: idle address and data show the inverse of the last value, so stale data cannot match
`timescale 1ns/1ps
`default_nettype none
module sfrx_cpu_model (
  input wire logic clk_sys, // system clock
  output logic cpu_wr, // write strobe
  output logic cpu_rd, // read strobe
  output logic [7:0] cpu_addr, // register address
  output logic [7:0] cpu_wdata, // write data
  input wire logic [7:0] cpu_rdata, // read data
  input wire logic cpu_rvalid, // read data valid
  input wire logic cpu_rhit // read hit
);
  initial begin
    cpu_wr = 1'b0;
    cpu_rd = 1'b0;
    cpu_addr = 8'h00;
    cpu_wdata = 8'h00;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    cpu_wr = 1'b1;
    cpu_addr = a;
    cpu_wdata = d;
    @(negedge clk_sys);
    cpu_wr = 1'b0;
    cpu_addr = ~a;
    cpu_wdata = ~d;
  endtask

  // data is only trusted while valid and hit, anything else returns unknown
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_sys);
    cpu_rd = 1'b1;
    cpu_addr = a;
    @(negedge clk_sys);
    cpu_rd = 1'b0;
    cpu_addr = ~a;
    d = (cpu_rvalid === 1'b1 && cpu_rhit === 1'b1) ? cpu_rdata : 8'hxx;
  endtask

  // area bits change here by read, and-mask, or-mask, write back
  task automatic rmw(input logic [7:0] a, input logic [7:0] am, input logic [7:0] om);
    logic [7:0] d;
    rd(a, d);
    wr(a, (d & am) | om);
  endtask
endmodule
`default_nettype wire

// *** sim/test_sfrx_top.sv ***
// Purpose: self-checking bench for area select, page registers and write guard
// Assumes: inputs change at falling clk_sys through the cpu model
// Notes: expected values come from the register layout, never from the block
`timescale 1ns/1ps
`default_nettype none
module test_sfrx_top import sfrx_pkg::*; ;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic cpu_wr, cpu_rd, cpu_rvalid, cpu_rhit, map_select_bit;
  logic [7:0] cpu_addr, cpu_wdata, cpu_rdata;
  logic [SFRX_NMOD-1:0][2:0] page_active;
  logic [3:0] clock_divider_setting;
  logic watchdog_enable_bit, power_down_request, slow_down_request, guard_blocked;
  wire logic [7:0] prot;
  int n_errors = 0;
  int check_count = 0;
  assign prot = {1'b0, slow_down_request, power_down_request, watchdog_enable_bit,
    clock_divider_setting};
  always #4 clk_sys = ~clk_sys;

  sfrx_top u_sfrx_top (.clk_sys(clk_sys), .rstn(rstn), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd),
    .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
    .cpu_rvalid(cpu_rvalid), .cpu_rhit(cpu_rhit), .map_select_bit(map_select_bit),
    .page_active(page_active), .clock_divider_setting(clock_divider_setting),
    .watchdog_enable_bit(watchdog_enable_bit), .power_down_request(power_down_request),
    .slow_down_request(slow_down_request), .guard_blocked(guard_blocked));
  sfrx_cpu_model u_sfrx_cpu_model (.clk_sys(clk_sys), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd),
    .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
    .cpu_rvalid(cpu_rvalid), .cpu_rhit(cpu_rhit));

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp, input string nm);
    logic [7:0] d;
    u_sfrx_cpu_model.rd(a, d);
    chk(nm, d, exp);
  endtask

  task automatic t_reset;
    rdchk(SFRX_AREA_ADDR, 8'h04, "area");
    rdchk(SFRX_GUARD_ADDR, 8'h07, "guard");
    rdchk(SFRX_PG_PORT_ADDR, 8'h00, "page");
    chk("prot", prot, 8'h00);
  endtask

  task automatic t_area;
    logic [7:0] d;
    u_sfrx_cpu_model.rmw(SFRX_AREA_ADDR, 8'hff, 8'h01);
    chk("map", {7'h0, map_select_bit}, 8'h01);
    rdchk(SFRX_AREA_ADDR, 8'h05, "area");
    u_sfrx_cpu_model.wr(SFRX_AREA_ADDR, 8'hfb);
    rdchk(SFRX_AREA_ADDR, 8'h01, "area");
    u_sfrx_cpu_model.wr(SFRX_PG_PORT_ADDR, 8'h05);
    repeat (20) @(negedge clk_sys);
    chk("page", {5'h0, page_active[0]}, 8'h00);
    u_sfrx_cpu_model.rd(SFRX_PG_PORT_ADDR, d);
    chk("rvalid_rhit", {6'h0, cpu_rvalid, cpu_rhit}, 8'h02);
    chk("rdata", cpu_rdata, 8'h00);
    chk("map", {7'h0, map_select_bit}, 8'h01);
    u_sfrx_cpu_model.rmw(SFRX_AREA_ADDR, 8'hfe, 8'h04);
    chk("map", {7'h0, map_select_bit}, 8'h00);
  endtask

  task automatic t_page;
    logic [7:0] pa [4] = '{SFRX_PG_PORT_ADDR, SFRX_PG_ADC_ADDR, SFRX_PG_CC_ADDR,
      SFRX_PG_SCU_ADDR};
    logic [1:0] s;
    for (int m = 0; m < 4; m++) begin
      s = 2'(m);
      u_sfrx_cpu_model.wr(pa[m], 8'h0d);
      chk("page", {5'h0, page_active[m]}, 8'h05);
      rdchk(pa[m], 8'h05, "page");
      u_sfrx_cpu_model.wr(pa[m], {2'b10, s, 4'h3});
      chk("page", {5'h0, page_active[m]}, 8'h03);
      u_sfrx_cpu_model.wr(pa[m], {2'b01, ~s, 4'h6});
      chk("page", {5'h0, page_active[m]}, 8'h06);
      u_sfrx_cpu_model.wr(pa[m], {2'b11, s, 4'h1});
      chk("page", {5'h0, page_active[m]}, 8'h05);
    end
  endtask

  task automatic t_guard;
    u_sfrx_cpu_model.wr(SFRX_PROT_ADDR, 8'h7f);
    chk("prot", prot, 8'h00);
    u_sfrx_cpu_model.wr(SFRX_GUARD_ADDR, 8'h98);
    chk("blk", {7'h0, guard_blocked}, 8'h00);
    u_sfrx_cpu_model.wr(SFRX_PROT_ADDR, 8'h5a);
    chk("prot", prot, 8'h5a);
    repeat (29) @(negedge clk_sys);
    chk("blk", {7'h0, guard_blocked}, 8'h00);
    @(negedge clk_sys);
    chk("blk", {7'h0, guard_blocked}, 8'h01);
    u_sfrx_cpu_model.wr(SFRX_GUARD_ADDR, 8'h98);
    repeat (20) @(negedge clk_sys);
    u_sfrx_cpu_model.wr(SFRX_GUARD_ADDR, 8'h98);
    repeat (31) @(negedge clk_sys);
    chk("blk", {7'h0, guard_blocked}, 8'h00);
    @(negedge clk_sys);
    chk("blk", {7'h0, guard_blocked}, 8'h01);
    u_sfrx_cpu_model.wr(SFRX_GUARD_ADDR, 8'h98);
    u_sfrx_cpu_model.wr(SFRX_GUARD_ADDR, 8'ha8);
    chk("blk", {7'h0, guard_blocked}, 8'h01);
    u_sfrx_cpu_model.wr(SFRX_PROT_ADDR, 8'h00);
    chk("prot", prot, 8'h5a);
    u_sfrx_cpu_model.wr(SFRX_GUARD_ADDR, 8'h00);
    rdchk(SFRX_GUARD_ADDR, 8'h07, "guard");
    u_sfrx_cpu_model.wr(SFRX_GUARD_ADDR, 8'hc0);
    rdchk(SFRX_GUARD_ADDR, 8'h00, "guard");
    u_sfrx_cpu_model.wr(SFRX_PROT_ADDR, 8'h00);
    chk("prot", prot, 8'h00);
    u_sfrx_cpu_model.wr(SFRX_GUARD_ADDR, 8'hc3);
    rdchk(SFRX_GUARD_ADDR, 8'h07, "guard");
  endtask

  task automatic conclude;
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // whole run is well under 500 cycles
  initial begin
    #20000;
    n_errors++;
    conclude;
  end

  initial begin
    repeat (10) @(negedge clk_sys);
    rstn = 1'b1;
    t_reset;
    t_area;
    t_page;
    t_guard;
    conclude;
  end
endmodule
`default_nettype wire
